// ### hw/ambient_zone_regs.sv
// APB register bank for ambient zone report, sensor loads and LED level
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "zone_brightness_consts.svh"
module ambient_zone_regs
  import zone_brightness_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Digitised level of the active sensor input
  input  wire sense_t            sense_level_in,
  input  wire logic              sense_valid_in,
  // Open-drain interrupt pin and level interrupt
  output logic                   int_n_out,
  output logic                   int_n_oe_out,
  output logic                   irq_out,
  // Resistor network controls
  output load_code_t             first_load_code_out,
  output logic                   first_hiz_out,
  output load_code_t             second_load_code_out,
  output logic                   second_hiz_out,
  // LED current controls
  output logic [2:0]             full_scale_sel_out,
  output curve_e                 led_curve_out,
  output frac_t                  led_current_frac_out,
  output zone_t                  zone_out
);

  // Highest index used is 8'ha0, byte address needs ten bits
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must be between 10 and 32");
  end

  // Register state
  logic [7:0]  gen_config_r;
  zone_t       zone_report_r;
  logic        zone_flag_r;
  logic [7:0]  load_select_r;
  level_code_t led_level_r;
  sense_t      bound_r [4];
  logic        int_status_r;
  logic        int_mask_r;
  logic [31:0] prdata_r;
  logic        slverr_r;

  // Bus decode
  logic [7:0]  idx;
  logic        idx_hit;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_mux;
  logic        mapped;

  // Classifier link
  zone_t       zone_live;
  logic        zone_change;

  assign setup_ph  = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;

  // Word index; bits above the index must be zero to hit
  assign idx     = paddr_in[9:2];
  assign idx_hit = (paddr_in[1:0] == 2'b00) &&
                   ((paddr_in >> 10) == '0);

  assign wr_en = access_ph && pwrite_in && idx_hit && pstrb_in[0];
  assign rd_en = access_ph && !pwrite_in && idx_hit;

  // Read data and map check for the current index
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (idx)
      `IDX_GEN_CONFIG:  rd_mux[7:0] = gen_config_r;
      `IDX_ZONE_REPORT: begin
        rd_mux[`ZONE_MSB:0]    = zone_report_r;
        rd_mux[`ZONE_FLAG_BIT] = zone_flag_r;
      end
      `IDX_LOAD_SELECT: rd_mux[7:0] = load_select_r;
      `IDX_INT_STATUS:  rd_mux[`INT_ZONE_BIT] = int_status_r;
      `IDX_INT_MASK:    rd_mux[`INT_ZONE_BIT] = int_mask_r;
      `IDX_LED_LEVEL:   rd_mux[`LEVEL_MSB:0] = led_level_r;
      `IDX_BOUNDARY_BASE:        rd_mux[7:0] = bound_r[0];
      `IDX_BOUNDARY_BASE + 8'h1: rd_mux[7:0] = bound_r[1];
      `IDX_BOUNDARY_BASE + 8'h2: rd_mux[7:0] = bound_r[2];
      `IDX_BOUNDARY_BASE + 8'h3: rd_mux[7:0] = bound_r[3];
      default: mapped = 1'b0;
    endcase
    if (!idx_hit) begin
      mapped = 1'b0;
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data and error captured in setup, shown in access
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite_in ? 32'h0000_0000 : rd_mux;
      slverr_r <= !mapped;
    end
  end

  // Zero wait states; error only during the access phase
  assign pready_out  = 1'b1;
  assign pslverr_out = access_ph && slverr_r;
  assign prdata_out  = prdata_r;

  // General configuration: curve select and full-scale select
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gen_config_r <= `RST_GEN_CONFIG;
    end else if (wr_en && idx == `IDX_GEN_CONFIG) begin
      gen_config_r <= pwdata_in[7:0];
    end
  end

  // Sensor load select, both nibbles writable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_select_r <= `RST_LOAD_SELECT;
    end else if (wr_en && idx == `IDX_LOAD_SELECT) begin
      load_select_r <= pwdata_in[7:0];
    end
  end

  // LED level; bit 7 is dropped and reads zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      led_level_r <= level_code_t'(`RST_LED_LEVEL);
    end else if (wr_en && idx == `IDX_LED_LEVEL) begin
      led_level_r <= pwdata_in[`LEVEL_MSB:0];
    end
  end

  // Zone boundaries
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bound_r[0] <= `RST_BOUNDARY0;
      bound_r[1] <= `RST_BOUNDARY1;
      bound_r[2] <= `RST_BOUNDARY2;
      bound_r[3] <= `RST_BOUNDARY3;
    end else if (wr_en && idx[7:2] == 6'(`IDX_BOUNDARY_BASE >> 2)) begin
      bound_r[idx[1:0]] <= pwdata_in[7:0];
    end
  end

  // Zone detection against the four boundaries
  zone_classifier u_zone (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .level_in   (sense_level_in),
    .valid_in   (sense_valid_in),
    .bound0_in  (bound_r[0]),
    .bound1_in  (bound_r[1]),
    .bound2_in  (bound_r[2]),
    .bound3_in  (bound_r[3]),
    .zone_out   (zone_live),
    .change_out (zone_change)
  );

  // Zone report: number follows each change
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      zone_report_r <= zone_t'(`RST_ZONE_REPORT);
    end else if (zone_change) begin
      zone_report_r <= zone_live;
    end
  end

  // Change flag doubles as the pin pull; set beats read clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      zone_flag_r <= 1'b0;
    end else if (zone_change) begin
      zone_flag_r <= 1'b1;
    end else if (rd_en && idx == `IDX_ZONE_REPORT) begin
      zone_flag_r <= 1'b0;
    end
  end

  // Open-drain pin: drive low while a change awaits a read
  assign int_n_out    = 1'b0;
  assign int_n_oe_out = zone_flag_r;

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_status_r <= 1'(`RST_INT_STATUS >> `INT_ZONE_BIT);
    end else if (zone_change) begin
      int_status_r <= 1'b1;
    end else if (wr_en && idx == `IDX_INT_STATUS &&
                 pwdata_in[`INT_ZONE_BIT]) begin
      int_status_r <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_mask_r <= 1'(`RST_INT_MASK >> `INT_ZONE_BIT);
    end else if (wr_en && idx == `IDX_INT_MASK) begin
      int_mask_r <= pwdata_in[`INT_ZONE_BIT];
    end
  end

  assign irq_out = int_status_r && int_mask_r;

  // Resistor network: code passed on, zero means open input
  assign first_load_code_out  =
    load_select_r[`FIRST_LOAD_LSB +: 4];
  assign second_load_code_out =
    load_select_r[`SECOND_LOAD_LSB +: 4];
  assign first_hiz_out  =
    load_select_r[`FIRST_LOAD_LSB +: 4] == 4'h0;
  assign second_hiz_out =
    load_select_r[`SECOND_LOAD_LSB +: 4] == 4'h0;

  // Full-scale select and curve select for the current DAC
  assign full_scale_sel_out = gen_config_r[`FULL_SCALE_LSB +: 3];
  assign led_curve_out      = curve_e'(gen_config_r[`CURVE_BIT]);
  assign zone_out           = zone_report_r;

  // Level to fraction of full scale
  led_curve_map u_curve (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .code_in  (led_level_r),
    .curve_in (curve_e'(gen_config_r[`CURVE_BIT])),
    .frac_out (led_current_frac_out)
  );

endmodule : ambient_zone_regs

// ### hw/led_curve_map.sv
// Maps the seven-bit LED level to a fraction of full-scale current
`timescale 1ns/1ps
`include "zone_brightness_consts.svh"
module led_curve_map
  import zone_brightness_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire level_code_t code_in,
  input  wire curve_e      curve_in,
  output frac_t            frac_out
);

  frac_t frac_nxt;
  frac_t frac_r;
  frac_t lin_val;
  frac_t exp_val;

  // Linear: code*32 + code/4 gives 0 at 0 and 4095 at 127
  assign lin_val = {code_in, 5'h00} + {7'h00, code_in[6:2]};

  // Exponential: top three bits are the octave, low four the step
  assign exp_val = frac_t'({7'h00, 1'b1, code_in[3:0]} << code_in[6:4]);

  // Pick the curve; both ends are forced exactly
  always_comb begin
    if (curve_in == CURVE_LIN) begin
      frac_nxt = lin_val;
    end else begin
      frac_nxt = exp_val;
    end
    if (code_in == 7'h00) begin
      frac_nxt = 12'h000;
    end else if (code_in == 7'h7f) begin
      frac_nxt = `FULL_SCALE_FRAC;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frac_r <= 12'h000;
    end else begin
      frac_r <= frac_nxt;
    end
  end

  assign frac_out = frac_r;

endmodule : led_curve_map

// ### hw/zone_brightness_consts.svh
// Register indexes, field positions and reset values of the zone block
//
// Overview of operation
// - Zone report holds zone 0..4, upper bits zero
// - New zone report pulls interrupt pin low
// - Reading zone report releases interrupt pin
// - Bit 3 flags change, cleared by report read
// - Load select low nibble first, high second
// - Load code zero leaves input high impedance
// - Codes 1..15 select decreasing resistances
// - Seven-bit LED level, bit 7 unused, reset 7f
// - Level scales full-scale current, config bits 4:2
// - Config bit 1 picks exponential or linear curve
`ifndef ZONE_BRIGHTNESS_CONSTS_SVH
`define ZONE_BRIGHTNESS_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_GEN_CONFIG    8'h10
`define IDX_ZONE_REPORT   8'h40
`define IDX_LOAD_SELECT   8'h41
`define IDX_INT_STATUS    8'h50
`define IDX_INT_MASK      8'h51
`define IDX_BOUNDARY_BASE 8'h60
`define IDX_LED_LEVEL     8'ha0

// Reset values
`define RST_GEN_CONFIG    8'h00
`define RST_ZONE_REPORT   8'h00
`define RST_LOAD_SELECT   8'h00
`define RST_INT_STATUS    8'h00
`define RST_INT_MASK      8'h00
`define RST_LED_LEVEL     8'h7f
`define RST_BOUNDARY0     8'h33
`define RST_BOUNDARY1     8'h66
`define RST_BOUNDARY2     8'h99
`define RST_BOUNDARY3     8'hcc

// Field positions
`define ZONE_MSB          2
`define ZONE_FLAG_BIT     3
`define FIRST_LOAD_LSB    0
`define SECOND_LOAD_LSB   4
`define LEVEL_MSB         6
`define CURVE_BIT         1
`define FULL_SCALE_LSB    2
`define INT_ZONE_BIT      0

// Fraction of full scale that means exactly 100 percent
`define FULL_SCALE_FRAC   12'hfff

`endif

// ### hw/zone_brightness_pkg.sv
// Types shared by the zone and brightness register block
package zone_brightness_pkg;

  typedef logic [2:0]  zone_t;
  typedef logic [3:0]  load_code_t;
  typedef logic [6:0]  level_code_t;
  typedef logic [11:0] frac_t;
  typedef logic [7:0]  sense_t;

  typedef enum logic {
    CURVE_EXP = 1'b0,
    CURVE_LIN = 1'b1
  } curve_e;

endpackage : zone_brightness_pkg

// ### hw/zone_classifier.sv
// Classifies the digitised sensor level into one of five zones
`timescale 1ns/1ps
`include "zone_brightness_consts.svh"
module zone_classifier
  import zone_brightness_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire sense_t level_in,
  input  wire logic   valid_in,
  input  wire sense_t bound0_in,
  input  wire sense_t bound1_in,
  input  wire sense_t bound2_in,
  input  wire sense_t bound3_in,
  output zone_t       zone_out,
  output logic        change_out
);

  zone_t zone_nxt;
  zone_t zone_r;
  logic  change_r;

  // Count boundaries at or below the level; ordering is trusted
  always_comb begin
    zone_nxt = 3'h0;
    if (level_in >= bound0_in) zone_nxt = 3'h1;
    if (level_in >= bound1_in) zone_nxt = 3'h2;
    if (level_in >= bound2_in) zone_nxt = 3'h3;
    if (level_in >= bound3_in) zone_nxt = 3'h4;
  end

  // Keep last reported zone, pulse only on a difference
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      zone_r   <= 3'h0;
      change_r <= 1'b0;
    end else begin
      change_r <= valid_in && (zone_nxt != zone_r);
      if (valid_in) begin
        zone_r <= zone_nxt;
      end
    end
  end

  assign zone_out   = zone_r;
  assign change_out = change_r;

endmodule : zone_classifier

// ### verif/apb_host_model.sv
// Host processor model that issues APB transfers
`timescale 1ns/1ps
module apb_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out = 1'b0,
  output logic             penable_out = 1'b0,
  output logic             pwrite_out = 1'b0,
  output logic [11:0]      paddr_out = 12'h000,
  output logic [31:0]      pwdata_out = 32'h0,
  output logic [3:0]       pstrb_out = 4'h0
);
  // One transfer: setup, access until ready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    pstrb_out   <= s;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out  <= ~d; // Released data shows no stale value
  endtask : xfer
endmodule : apb_host_model

// ### verif/testbench.sv
// Self-checking bench for the zone and LED level register block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module testbench
  import zone_brightness_pkg::*;
;
  logic clk_in = 1'b0, rst_n_in = 1'b0, sense_valid_in = 1'b0;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, last_err;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [3:0]  pstrb_in;
  sense_t      sense_level_in = 8'h00;
  logic        int_n_out, int_n_oe_out, irq_out, first_hiz_out;
  logic        second_hiz_out;
  load_code_t  first_load_code_out, second_load_code_out;
  logic [2:0]  full_scale_sel_out;
  curve_e      led_curve_out;
  frac_t       led_current_frac_out;
  zone_t       zone_out;
  int          n_fail = 0, n_tests = 0;

  ambient_zone_regs DUT (.clk_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
    .pslverr_out, .sense_level_in, .sense_valid_in, .int_n_out,
    .int_n_oe_out, .irq_out, .first_load_code_out, .first_hiz_out,
    .second_load_code_out, .second_hiz_out, .full_scale_sel_out,
    .led_curve_out, .led_current_frac_out, .zone_out);
  apb_host_model host (.clk_in, .prdata_in(prdata_out),
    .pready_in(pready_out), .pslverr_in(pslverr_out), .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
    .pwdata_out(pwdata_in), .pstrb_out(pstrb_in));

  // Clock and watchdog
  initial forever #20 clk_in = ~clk_in;
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] r;
    host.xfer(1'b1, a, d, s, r, last_err);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string n);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, 4'h0, r, last_err);
    `CHK(n, e, r)
  endtask : rd
  task automatic send(input sense_t l);
    @(posedge clk_in);
    sense_level_in <= l;
    sense_valid_in <= 1'b1;
    @(posedge clk_in);
    sense_level_in <= ~l;
    sense_valid_in <= 1'b0;
    tick(2);
  endtask : send
  function automatic frac_t fx(input logic lin, input level_code_t c);
    if (c == 7'h7f) return 12'hfff;
    if (lin) return 12'({c, 5'h00}) + 12'(c[6:2]);
    if (c == 7'h00) return 12'h000;
    return 12'({1'b1, c[3:0]}) << c[6:4];
  endfunction : fx

  task automatic t_reset;
    rd(12'h100, 32'h00, "zone report");
    rd(12'h104, 32'h00, "load select");
    rd(12'h280, 32'h7f, "led level");
    `CHK("frac", 12'hfff, led_current_frac_out)
    `CHK("hiz", 2'b11, {first_hiz_out, second_hiz_out})
    $display("reset test done");
  endtask : t_reset
  // Zone steps at default and at reprogrammed boundaries
  task automatic t_zone;
    sense_t lv[5] = '{8'h33, 8'h99, 8'hcc, 8'h32, 8'h66};
    zone_t  ez[5] = '{3'd1, 3'd3, 3'd4, 3'd0, 3'd2};
    foreach (lv[i]) begin
      send(lv[i]);
      `CHK("zone", ez[i], zone_out)
      `CHK("pin", 2'b10, {int_n_oe_out, int_n_out})
      rd(12'h100, 32'({1'b1, ez[i]}), "report flag");
      tick(0);
      `CHK("pin off", 1'b0, int_n_oe_out)
      rd(12'h100, 32'(ez[i]), "report clear");
    end
    send(8'h70);
    `CHK("same zone", 1'b0, int_n_oe_out)
    for (int b = 0; b < 4; b++) begin
      wr(12'h180 + 12'(4 * b), 32'(16 * (b + 1)), 4'h1);
    end
    rd(12'h18c, 32'h40, "boundary readback");
    send(8'h35);
    `CHK("new bounds", 3'd3, zone_out)
    rd(12'h100, 32'h0b, "new bounds report");
    for (int b = 0; b < 4; b++) begin
      wr(12'h180 + 12'(4 * b), 32'(51 * (b + 1)), 4'h1);
    end
    $display("zone test done");
  endtask : t_zone
  task automatic t_irq;
    wr(12'h144, 32'h1, 4'h1);
    send(8'h10);
    `CHK("irq on", 1'b1, irq_out)
    rd(12'h140, 32'h1, "status");
    wr(12'h144, 32'h0, 4'h1);
    tick(0);
    `CHK("irq masked", 1'b0, irq_out)
    wr(12'h144, 32'h1, 4'h1);
    tick(0);
    `CHK("irq unmasked", 1'b1, irq_out)
    wr(12'h140, 32'h1, 4'h1);
    tick(0);
    `CHK("irq cleared", 1'b0, irq_out)
    rd(12'h100, 32'h8, "report");
    $display("irq test done");
  endtask : t_irq
  task automatic t_load;
    for (int c = 0; c < 16; c++) begin
      wr(12'h104, 32'({4'(15 - c), 4'(c)}), 4'h1);
      tick(0);
      `CHK("first code", 4'(c), first_load_code_out)
      `CHK("second code", 4'(15 - c), second_load_code_out)
      `CHK("hiz", {c == 0, c == 15}, {first_hiz_out, second_hiz_out})
      rd(12'h104, 32'({4'(15 - c), 4'(c)}), "load readback");
    end
    $display("load test done");
  endtask : t_load
  task automatic t_level;
    level_code_t cs[4] = '{7'h00, 7'h01, 7'h25, 7'h7f};
    for (int v = 0; v < 2; v++) begin
      wr(12'h040, 32'({3'(5 + v), 1'(v), 1'b0}), 4'h1);
      tick(0);
      `CHK("full scale", 3'(5 + v), full_scale_sel_out)
      `CHK("curve", 1'(v), led_curve_out)
      foreach (cs[i]) begin
        wr(12'h280, 32'(cs[i]), 4'h1);
        tick(2);
        `CHK("frac", fx(1'(v), cs[i]), led_current_frac_out)
      end
    end
    wr(12'h280, 32'hff, 4'h1);
    rd(12'h280, 32'h7f, "bit7 unused");
    $display("level test done");
  endtask : t_level
  task automatic t_err;
    rd(12'h3fc, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, last_err)
    wr(12'h100, 32'hff, 4'h1);
    rd(12'h100, 32'h0, "report read only");
    wr(12'h280, 32'h05, 4'h0);
    rd(12'h280, 32'h7f, "no strobe");
    $display("error test done");
  endtask : t_err

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_zone();
    t_irq();
    t_load();
    t_level();
    t_err();
    finish_test();
  end
endmodule : testbench

// ### verif/zone_regs_monitor.sv
// Concurrent checks on the zone and LED level register block ports
`timescale 1ns/1ps
module zone_regs_monitor
  import zone_brightness_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [3:0]        pstrb_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              sense_valid_in,
  input wire logic              int_n_out,
  input wire logic              int_n_oe_out,
  input wire logic              irq_out,
  input wire load_code_t        first_load_code_out,
  input wire logic              first_hiz_out,
  input wire load_code_t        second_load_code_out,
  input wire logic              second_hiz_out,
  input wire logic [2:0]        full_scale_sel_out,
  input wire curve_e            led_curve_out,
  input wire frac_t             led_current_frac_out,
  input wire zone_t             zone_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc;
  logic wr;
  logic rd_rep;
  // Decoded bus cycles
  assign acc    = psel_in && penable_in;
  assign wr     = acc && pwrite_in && pstrb_in[0];
  assign rd_rep = acc && !pwrite_in && paddr_in == 'h100;

  a_zone_range: assert property (zone_out <= 3'd4)
    else $error("zone number out of range");
  a_upper_zero: assert property (rd_rep |-> prdata_out[31:4] == 28'h0)
    else $error("zone report upper bits set");
  a_pin_low: assert property (int_n_oe_out |-> !int_n_out)
    else $error("interrupt pin not driven low");
  a_change_pin: assert property ($changed(zone_out) |-> int_n_oe_out)
    else $error("zone change without pin");
  a_read_release: assert property (rd_rep && !$past(sense_valid_in)
    && !$past(sense_valid_in, 2) |=> !int_n_oe_out)
    else $error("report read kept pin");
  a_load_write: assert property (wr && paddr_in == 'h104 |=>
    first_load_code_out == $past(pwdata_in[3:0])
    && second_load_code_out == $past(pwdata_in[7:4]))
    else $error("load codes wrong");
  a_hiz_zero: assert property (first_hiz_out == (first_load_code_out == 4'h0)
    && second_hiz_out == (second_load_code_out == 4'h0))
    else $error("high impedance flag wrong");
  a_cfg_fields: assert property (wr && paddr_in == 'h040 |=>
    full_scale_sel_out == $past(pwdata_in[4:2])
    && led_curve_out == $past(pwdata_in[1]))
    else $error("config fields wrong");
  a_level_full: assert property (wr && paddr_in == 'h280
    && pwdata_in[6:0] == 7'h7f |-> ##2 led_current_frac_out == 12'hfff)
    else $error("top level not full scale");
  a_level_off: assert property (wr && paddr_in == 'h280
    && pwdata_in[6:0] == 7'h00 |-> ##2 led_current_frac_out == 12'h000)
    else $error("level zero not off");

  // Main scenarios reached
  c_read_clear: cover property (rd_rep && int_n_oe_out);
  c_zone_event: cover property ($rose(int_n_oe_out));
  c_irq: cover property ($rose(irq_out));
endmodule : zone_regs_monitor

bind ambient_zone_regs zone_regs_monitor #(.ADDR_W(ADDR_W)) mon (
  .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pstrb_in, .prdata_out, .sense_valid_in, .int_n_out,
  .int_n_oe_out, .irq_out, .first_load_code_out, .first_hiz_out,
  .second_load_code_out, .second_hiz_out, .full_scale_sel_out,
  .led_curve_out, .led_current_frac_out, .zone_out
);
